// File: mem_partner.sv
// far side memory: answers each request after a chosen latency
// assumes the executor's memory port on the same clock
`timescale 1ns/1ns
`default_nettype none
module mem_partner (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [14:0] addr_i,
   input wire logic [1:0] lat_i,
   output logic ack_o,
   output logic [27:1] rdata_o
);
   logic [1:0] cnt_r;
   wire logic hit = req_i & ~ack_o & (cnt_r >= lat_i);
   always_ff @(posedge clk_i) begin
      if (rst_i | ack_o) begin
         cnt_r <= 2'h0;
      end else if (req_i & ~hit) begin
         cnt_r <= cnt_r + 2'h1;
      end
      ack_o <= ~rst_i & hit;
      // data only good in the ack cycle of a read; toggles otherwise so stale bits are never trusted
      rdata_o <= rst_i ? 27'h0 : (hit & ~we_i) ? {addr_i[11:0], addr_i ^ 15'h0123} : ~rdata_o;
   end
endmodule
`default_nettype wire

// File: misc_exec_params.svh
// constants of the miscellaneous instruction executor
// assumes nothing; included by the package and the bench
`ifndef MISC_EXEC_PARAMS_SVH
`define MISC_EXEC_PARAMS_SVH
// operation codes (octal 05, 77, 03, 76)
`define OP_STORE_TAPE 6'h05
`define OP_WAIT 6'h3f
`define OP_SHOW 6'h03
`define OP_CLOCK 6'h3e
// instruction field positions
`define F_IND 25
`define F_IDX_HI 24
`define F_IDX_LO 21
`define F_OP_HI 20
`define F_OP_LO 15
`define F_SEL_HI 14
`define F_SEL_LO 11
`define F_M_HI 10
`define F_M_LO 1
// tape channel selectors
`define SEL_BWR 4'h8
`define SEL_BRD 4'h4
`define SEL_AWR 4'h2
`define SEL_ARD 4'h1
`define SEL_NONE 4'h0
`define SIGN_POS 1'h0
// instruction pointer steps
`define STEP_LOAD 2'h0
`define STEP_ONE 2'h1
`define STEP_TWO 2'h2
// register map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PANEL 8'h08
`define REG_TIME 8'h0c
`define CTRL_RST 1'h1
`define ST_HALT_BIT 0
`define ST_BUSY_BIT 1
`define ST_ILL_BIT 2
`define ST_LOST_BIT 3
`define ST_TOK_BIT 4
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// File: misc_exec_pkg.sv
// types of the miscellaneous instruction executor
// assumes the params header is on the include path
`default_nettype none
`include "misc_exec_params.svh"
package misc_exec_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_IND = 6'h04,
      ST_EX = 6'h08,
      ST_EX2 = 6'h10,
      ST_HALT = 6'h20
   } state_t;
endpackage
`default_nettype wire

// File: misc_instruction_exec.sv
// executor for store-tape-status, wait, panel-show and read-wallclock
// assumes same-clock fetch, memory, index and tape logic; clock pins and run button async
// Contract
// RL1: store-tape-status, code 05, three cycles, copies chosen channel status to memory
// RL2: fields: bit 25 indirect, 24-21 index, 20-15 opcode, 14-11 selector, 10-1 address
// RL3: stored word: address bits 1-15, count bits 16-24, positive sign bit 25
// RL4: tape selector one-hot: 1000 basic write, 0100 basic read, 0010/0001 additional
// RL5: store-tape-status and wait honour indirect, no field selection
// RL6: wait, code 77, two cycles, loads pointer then stops fetching
// RL7: while halted, running peripheral and standby work continues to completion
// RL8: run button resumes at pointer; interrupt taken if indicator set during halt
// RL9: panel-show, code 03, two cycles, sends whole 27-bit word; selector 0000
// RL10: panel lights its display only with its selector in position 0
// RL11: panel-show allows indirect, rejects field selection and multiword operands
// RL12: read-wallclock, code 76, two cycles; expects zero indirect, index, address
// RL13: read inside update window gives invalid time, pointer advances by one
// RL14: read outside update window gives valid time, pointer advances by two
// RL15: time is five BCD digits: tenths, minutes, hours; bits 21-25 zero
// RL16: several accumulators selected: only the highest-numbered one is written
// RL17: no clock fitted: accumulator gets zeros, pointer advances by one
// RL18: after clock power loss every read sets overflow until clock is reset
// RL19: read-wallclock applies no indirect, field selection or multiword operand
// RL20: address is field plus selected index, zero means none; indirect one fetch
`timescale 1ns/1ns
`default_nettype none
module misc_instruction_exec
   import misc_exec_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic [25:1] INSTR_I,
   input wire logic INSTR_VALID_I,
   output logic INSTR_READY_O,
   input wire logic [224:0] IDX_REGS_I,
   output logic MEM_REQ_O,
   output logic MEM_WE_O,
   output logic [14:0] MEM_ADDR_O,
   output logic [27:1] MEM_WDATA_O,
   input wire logic [27:1] MEM_RDATA_I,
   input wire logic MEM_ACK_I,
   input wire logic [95:0] TAPE_STATUS_I,
   output logic ACC_WE_O,
   output logic [2:0] ACC_NUM_O,
   output logic [25:1] ACC_DATA_O,
   output logic DONE_O,
   output logic [1:0] IP_STEP_O,
   output logic IP_LOAD_O,
   output logic [14:0] IP_VALUE_O,
   output logic HALTED_O,
   input wire logic INT_PENDING_I,
   output logic TAKE_INT_O,
   input wire logic PROGRAM_RUN_I,
   output logic OVF_SET_O,
   output logic ILLEGAL_O,
   output logic PANEL_STB_O,
   output logic [27:1] PANEL_DATA_O,
   input wire logic [19:0] CLK_TIME_I,
   input wire logic CLK_UPDATING_I,
   input wire logic CLK_PRESENT_I,
   input wire logic CLK_POWER_LOST_I,
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I
);
   state_t st_r, st_nxt;
   logic [23:0] pin_s1_r, pin_s2_r;
   logic run_q_r;
   logic [25:1] instr_r;
   logic [14:0] eff_r;
   logic rdy_r, halted_r, int_seen_r, take_int_r;
   logic mem_req_r, mem_we_r;
   logic [14:0] mem_addr_r;
   logic [27:1] mem_wdata_r;
   logic done_r, ip_load_r, acc_we_r, panel_stb_r, ovf_r, ill_r;
   logic [1:0] step_r;
   logic [14:0] ip_val_r;
   logic [2:0] acc_num_r;
   logic [25:1] acc_data_r, last_time_r;
   logic [27:1] panel_data_r;
   logic ctrl_fit_r, ill_st_r, time_ok_r;
   logic aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [14:0] idx_arr [0:15];
   logic [23:0] tape_arr [0:3];

   // clock pins and run button; time digits only settle outside the update window
   wire [23:0] pins = {PROGRAM_RUN_I, CLK_UPDATING_I, CLK_PRESENT_I, CLK_POWER_LOST_I,
      CLK_TIME_I};
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         pin_s1_r <= 24'h000000;
         pin_s2_r <= 24'h000000;
         run_q_r <= 1'b0;
      end else begin
         pin_s1_r <= pins;
         pin_s2_r <= pin_s1_r;
         run_q_r <= pin_s2_r[23];
      end
   end
   wire run_s = pin_s2_r[23];
   wire upd_s = pin_s2_r[22];
   wire pres_s = pin_s2_r[21];
   wire lost_s = pin_s2_r[20];
   wire [19:0] time_s = pin_s2_r[19:0];
   wire run_rise = run_s & ~run_q_r;

   assign idx_arr[0] = 15'h0000;
   genvar g;
   generate
      for (g = 1; g < 16; g++) begin : g_idx
         assign idx_arr[g] = IDX_REGS_I[15*g-1 -: 15];
      end
      for (g = 0; g < 4; g++) begin : g_tape
         assign tape_arr[g] = TAPE_STATUS_I[24*g+23 -: 24];
      end
   endgenerate

   wire ind_f = instr_r[`F_IND]; // RL2
   wire [3:0] idx_f = instr_r[`F_IDX_HI:`F_IDX_LO]; // RL2
   wire [5:0] op_f = instr_r[`F_OP_HI:`F_OP_LO]; // RL2
   wire [3:0] sel_f = instr_r[`F_SEL_HI:`F_SEL_LO]; // RL2
   wire [9:0] m_f = instr_r[`F_M_HI:`F_M_LO]; // RL2
   wire is_store_tape = op_f == `OP_STORE_TAPE;
   wire is_wait = op_f == `OP_WAIT;
   wire is_show = op_f == `OP_SHOW;
   wire is_clock = op_f == `OP_CLOCK;
   wire known = is_store_tape | is_wait | is_show | is_clock;
   wire [14:0] ix_addr = {5'h00, m_f} + idx_arr[idx_f]; // RL20
   // other codes are rejected rather than guessed at
   wire sel_onehot = (sel_f == `SEL_BWR) | (sel_f == `SEL_BRD) | (sel_f == `SEL_AWR) |
      (sel_f == `SEL_ARD); // RL4
   wire [23:0] tape_pick = sel_f[3] ? tape_arr[3] : sel_f[2] ? tape_arr[2] :
      sel_f[1] ? tape_arr[1] : tape_arr[0]; // RL4
   wire show_ok = sel_f == `SEL_NONE; // RL9 RL11
   wire no_clock = ~ctrl_fit_r | ~pres_s; // RL17
   wire clk_args_bad = ind_f | (idx_f != 4'h0) | (m_f != 10'h000); // RL12
   wire [2:0] acc_hi = sel_f[3] ? 3'h4 : sel_f[2] ? 3'h3 : sel_f[1] ? 3'h2 :
      sel_f[0] ? 3'h1 : 3'h0; // RL16
   wire mem_done = mem_req_r & MEM_ACK_I;
   wire take = (st_r == ST_IDLE) & INSTR_VALID_I & rdy_r;
   wire in_ex = st_r == ST_EX;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: if (take) st_nxt = ST_ADDR;
         ST_ADDR: begin
            if (!known) st_nxt = ST_IDLE;
            else if (ind_f && !is_clock) st_nxt = ST_IND; // RL5 RL11 RL19
            else st_nxt = ST_EX;
         end
         ST_IND: if (mem_done) st_nxt = ST_EX;
         ST_EX: begin
            if (is_wait) st_nxt = ST_HALT; // RL6
            else if (is_store_tape && sel_onehot) st_nxt = ST_EX2; // RL1
            else if (is_show && show_ok && !mem_done) st_nxt = ST_EX;
            else st_nxt = ST_IDLE;
         end
         ST_EX2: if (mem_done) st_nxt = ST_IDLE;
         ST_HALT: if (run_rise) st_nxt = ST_IDLE; // RL8
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         st_r <= ST_IDLE;
         instr_r <= 25'h0000000;
         eff_r <= 15'h0000;
      end else begin
         st_r <= st_nxt;
         if (take) instr_r <= INSTR_I;
         if (st_r == ST_ADDR) eff_r <= ix_addr; // RL20
         else if (st_r == ST_IND && mem_done) eff_r <= MEM_RDATA_I[15:1]; // RL20
      end
   end

   // memory: request held until acknowledged
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_addr_r <= 15'h0000;
         mem_wdata_r <= 27'h0000000;
      end else if (mem_done) begin
         mem_req_r <= 1'b0;
      end else if (st_r == ST_ADDR && st_nxt == ST_IND) begin
         mem_req_r <= 1'b1;
         mem_we_r <= 1'b0;
         mem_addr_r <= ix_addr;
      end else if (in_ex && is_show && show_ok && !mem_req_r) begin
         mem_req_r <= 1'b1;
         mem_we_r <= 1'b0;
         mem_addr_r <= eff_r;
      end else if (in_ex && st_nxt == ST_EX2) begin
         mem_req_r <= 1'b1;
         mem_we_r <= 1'b1;
         mem_addr_r <= eff_r;
         mem_wdata_r <= {2'h0, `SIGN_POS, tape_pick}; // RL1 RL3
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         done_r <= 1'b0;
         ip_load_r <= 1'b0;
         acc_we_r <= 1'b0;
         panel_stb_r <= 1'b0;
         ovf_r <= 1'b0;
         ill_r <= 1'b0;
         step_r <= `STEP_ONE;
         ip_val_r <= 15'h0000;
         acc_num_r <= 3'h0;
         acc_data_r <= 25'h0000000;
         panel_data_r <= 27'h0000000;
         last_time_r <= 25'h0000000;
         time_ok_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         ip_load_r <= 1'b0;
         acc_we_r <= 1'b0;
         panel_stb_r <= 1'b0;
         ovf_r <= 1'b0;
         ill_r <= st_r == ST_ADDR && !known;
         if (in_ex && is_wait) begin
            ip_load_r <= 1'b1; // RL6
            ip_val_r <= eff_r;
            done_r <= 1'b1;
            step_r <= `STEP_LOAD;
         end
         if (in_ex && is_clock) begin
            acc_we_r <= sel_f != `SEL_NONE; // RL16
            acc_num_r <= acc_hi; // RL16
            ill_r <= clk_args_bad; // RL12
            done_r <= 1'b1;
            if (no_clock) begin
               acc_data_r <= 25'h0000000; // RL17
               step_r <= `STEP_ONE; // RL17
               time_ok_r <= 1'b0;
            end else begin
               acc_data_r <= {5'h00, time_s}; // RL15
               step_r <= upd_s ? `STEP_ONE : `STEP_TWO; // RL13 RL14
               ovf_r <= lost_s; // RL18
               time_ok_r <= ~upd_s;
            end
            last_time_r <= no_clock ? 25'h0000000 : {5'h00, time_s};
         end
         if (in_ex && is_store_tape && !sel_onehot) begin
            ill_r <= 1'b1; // RL4
            done_r <= 1'b1;
            step_r <= `STEP_ONE;
         end
         if (in_ex && is_show && (!show_ok || mem_done)) begin
            ill_r <= ~show_ok; // RL11
            panel_stb_r <= show_ok; // RL9
            done_r <= 1'b1;
            step_r <= `STEP_ONE;
         end
         if (in_ex && is_show && mem_done) panel_data_r <= MEM_RDATA_I; // RL9
         if (st_r == ST_EX2 && mem_done) begin
            done_r <= 1'b1; // RL1
            step_r <= `STEP_ONE;
         end
      end
   end

   // halt stops fetch only; tape and peripheral logic outside is never held off
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         rdy_r <= 1'b0;
         halted_r <= 1'b0;
         int_seen_r <= 1'b0;
         take_int_r <= 1'b0;
      end else begin
         rdy_r <= st_nxt == ST_IDLE;
         halted_r <= st_nxt == ST_HALT; // RL6 RL7
         take_int_r <= st_r == ST_HALT && run_rise && (int_seen_r || INT_PENDING_I); // RL8
         if (st_r != ST_HALT || run_rise) int_seen_r <= 1'b0;
         else if (INT_PENDING_I) int_seen_r <= 1'b1; // RL8
      end
   end

   // register bus
   wire aw_take = AWVALID_I & awready_r;
   wire w_take = WVALID_I & wready_r;
   wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
   wire [7:0] wa = {aw_addr_r[7:2], 2'h0};
   wire [7:0] ra = {ARADDR_I[7:2], 2'h0};
   wire wr_ctrl = do_write & (wa == `REG_CTRL) & w_strb_r[0];
   wire wr_stat = do_write & (wa == `REG_STATUS) & w_strb_r[0];
   wire w_hit = (wa == `REG_CTRL) | (wa == `REG_STATUS) | (wa == `REG_PANEL) |
      (wa == `REG_TIME);
   wire r_hit = (ra == `REG_CTRL) | (ra == `REG_STATUS) | (ra == `REG_PANEL) |
      (ra == `REG_TIME);
   wire busy = (st_r != ST_IDLE) & (st_r != ST_HALT);
   wire [31:0] stat_word = {27'h0000000, time_ok_r, lost_s, ill_st_r, busy, halted_r};
   wire [31:0] rd_word = (ra == `REG_CTRL) ? {31'h00000000, ctrl_fit_r} :
      (ra == `REG_STATUS) ? stat_word :
      (ra == `REG_PANEL) ? {5'h00, panel_data_r} :
      (ra == `REG_TIME) ? {7'h00, last_time_r} : 32'h00000000;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else begin
         if (aw_take) aw_addr_r <= AWADDR_I;
         if (w_take) w_data_r <= WDATA_I;
         if (w_take) w_strb_r <= WSTRB_I;
         aw_hold_r <= do_write ? 1'b0 : (aw_hold_r | aw_take);
         w_hold_r <= do_write ? 1'b0 : (w_hold_r | w_take);
         awready_r <= do_write | ~(aw_hold_r | aw_take);
         wready_r <= do_write | ~(w_hold_r | w_take);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= `RESP_OKAY;
         rdata_r <= 32'h00000000;
         ctrl_fit_r <= `CTRL_RST;
         ill_st_r <= 1'b0;
      end else begin
         if (do_write) bvalid_r <= 1'b1;
         else if (BREADY_I) bvalid_r <= 1'b0;
         if (do_write) bresp_r <= w_hit ? `RESP_OKAY : `RESP_DECERR;
         if (ARVALID_I && arready_r) begin
            rvalid_r <= 1'b1;
            arready_r <= 1'b0;
            rdata_r <= rd_word;
            rresp_r <= r_hit ? `RESP_OKAY : `RESP_DECERR;
         end else if (rvalid_r && RREADY_I) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end else if (!rvalid_r) begin
            arready_r <= 1'b1;
         end
         if (wr_ctrl) ctrl_fit_r <= w_data_r[0];
         // a new error in the clearing cycle keeps the flag set
         if (ill_r) ill_st_r <= 1'b1;
         else if (wr_stat && w_data_r[`ST_ILL_BIT]) ill_st_r <= 1'b0;
      end
   end

   assign INSTR_READY_O = rdy_r;
   assign MEM_REQ_O = mem_req_r;
   assign MEM_WE_O = mem_we_r;
   assign MEM_ADDR_O = mem_addr_r;
   assign MEM_WDATA_O = mem_wdata_r;
   assign ACC_WE_O = acc_we_r;
   assign ACC_NUM_O = acc_num_r;
   assign ACC_DATA_O = acc_data_r;
   assign DONE_O = done_r;
   assign IP_STEP_O = step_r;
   assign IP_LOAD_O = ip_load_r;
   assign IP_VALUE_O = ip_val_r;
   assign HALTED_O = halted_r;
   assign TAKE_INT_O = take_int_r;
   assign OVF_SET_O = ovf_r;
   assign ILLEGAL_O = ill_r;
   assign PANEL_STB_O = panel_stb_r;
   assign PANEL_DATA_O = panel_data_r;
   assign AWREADY_O = awready_r;
   assign WREADY_O = wready_r;
   assign BRESP_O = bresp_r;
   assign BVALID_O = bvalid_r;
   assign ARREADY_O = arready_r;
   assign RDATA_O = rdata_r;
   assign RRESP_O = rresp_r;
   assign RVALID_O = rvalid_r;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   sequence store_go_s;
      st_r == ST_ADDR && is_store_tape && !ind_f && sel_onehot;
   endsequence
   sequence store_run_s;
      st_r == ST_EX ##1 st_r == ST_EX2;
   endsequence
   sequence clk_rd_s;
      in_ex && is_clock && !no_clock;
   endsequence
   store_steps_a: assert property (store_go_s |=> store_run_s) // RL1
      else $error("store-tape-status skipped a step");
   tape_word_a: assert property ($rose(mem_req_r && mem_we_r) |->
      mem_wdata_r[24:1] == $past(tape_pick) && mem_wdata_r[25] == `SIGN_POS) // RL3
      else $error("tape status word wrong");
   wait_halt_a: assert property (in_ex && is_wait |=> ip_load_r &&
      ip_val_r == $past(eff_r) && halted_r ##1 halted_r && !rdy_r) // RL6
      else $error("wait did not load and halt");
   halt_quiet_a: assert property (halted_r |-> !rdy_r && !mem_req_r) // RL7
      else $error("activity while halted");
   resume_go_a: assert property (st_r == ST_HALT && run_rise |=> !halted_r && rdy_r) // RL8
      else $error("run button did not resume");
   int_take_a: assert property (st_r == ST_HALT && run_rise && int_seen_r |=> take_int_r) // RL8
      else $error("interrupt lost across halt");
   panel_word_a: assert property (panel_stb_r |-> panel_data_r == $past(MEM_RDATA_I) &&
      $past(mem_req_r) && !ill_r) // RL9
      else $error("panel word wrong");
   clk_busy_a: assert property (clk_rd_s and upd_s |=> done_r && step_r == `STEP_ONE) // RL13
      else $error("update window read skipped");
   clk_skip_a: assert property (clk_rd_s and !upd_s |=> done_r && step_r == `STEP_TWO &&
      acc_data_r[25:21] == 5'h00) // RL14
      else $error("valid read did not skip");
   acc_high_a: assert property (acc_we_r |-> acc_num_r == acc_hi && acc_num_r != 3'h0) // RL16
      else $error("wrong accumulator written");
   no_clock_a: assert property (in_ex && is_clock && no_clock |=>
      acc_data_r == 25'h0000000 && step_r == `STEP_ONE && !ovf_r) // RL17
      else $error("missing clock not handled");
   ovf_lost_a: assert property (clk_rd_s and lost_s |=> ovf_r) // RL18
      else $error("overflow not set after power loss");
   lt_direct_a: assert property (st_r == ST_ADDR && is_clock |=> in_ex && !mem_req_r) // RL19
      else $error("clock read went indirect");
endmodule
`default_nettype wire

// File: misc_instruction_exec_bench.sv
// self-checking bench for the miscellaneous instruction executor
// assumes executor, package and memory partner compiled first
`timescale 1ns/1ns
`default_nettype none
`include "misc_exec_params.svh"
module misc_instruction_exec_bench;
   import misc_exec_pkg::*;
   logic CLK_SYS_I = 1'h0, RST_I = 1'h1, INSTR_VALID_I = 1'h0, INT_PENDING_I = 1'h0;
   logic PROGRAM_RUN_I = 1'h0, CLK_UPDATING_I = 1'h0, CLK_PRESENT_I = 1'h1;
   logic CLK_POWER_LOST_I = 1'h0, AWVALID_I = 1'h0, WVALID_I = 1'h0, BREADY_I = 1'h0;
   logic ARVALID_I = 1'h0, RREADY_I = 1'h0, MEM_ACK_I;
   logic [25:1] INSTR_I = 25'h0;
   logic [224:0] IDX_REGS_I = 225'h0;
   logic [95:0] TAPE_STATUS_I = 96'h0;
   logic [27:1] MEM_RDATA_I, MEM_WDATA_O, PANEL_DATA_O;
   logic [19:0] CLK_TIME_I = 20'h0;
   logic [7:0] AWADDR_I = 8'h0, ARADDR_I = 8'h0;
   logic [31:0] WDATA_I = 32'h0, RDATA_O;
   logic [3:0] WSTRB_I = 4'hf;
   logic INSTR_READY_O, MEM_REQ_O, MEM_WE_O, ACC_WE_O, DONE_O, IP_LOAD_O, HALTED_O, TAKE_INT_O;
   logic OVF_SET_O, ILLEGAL_O, PANEL_STB_O, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   logic [14:0] MEM_ADDR_O, IP_VALUE_O, a;
   logic [2:0] ACC_NUM_O;
   logic [25:1] ACC_DATA_O;
   logic [1:0] IP_STEP_O, BRESP_O, RRESP_O, lat = 2'h0;
   logic [31:0] seed = 32'hbb922054;
   logic [3:0] x;
   logic [9:0] m;
   logic [19:0] tm;
   logic [3:0] sels[4] = '{4'h3, 4'h1, 4'hb, 4'h8};
   logic [2:0] nums[4] = '{3'h2, 3'h1, 3'h4, 3'h4};
   logic [63:0] q_done[$], q_mem[$], q_axi[$], q_pan[$];
   int n_fail = 0, total_checks = 0, cyc = 0, n_ovf = 0, n_ill = 0, n_int = 0, h;

   misc_instruction_exec dut (.*);
   mem_partner far_mem (.clk_i(CLK_SYS_I), .rst_i(RST_I), .req_i(MEM_REQ_O), .we_i(MEM_WE_O),
      .addr_i(MEM_ADDR_O), .lat_i(lat), .ack_o(MEM_ACK_I), .rdata_o(MEM_RDATA_I));

   always #10 CLK_SYS_I = ~CLK_SYS_I;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic void rnd();
      seed = {1'h0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h0);
   endfunction
   function automatic logic [63:0] dn(input logic ld, we, input logic [1:0] st,
         input logic [27:0] d);
      return {32'h0, ld, we, st, d};
   endfunction
   function automatic logic [25:1] ins(input logic i, input logic [3:0] xi,
         input logic [5:0] op, input logic [3:0] s, input logic [9:0] mi);
      return {i, xi, op, s, mi};
   endfunction
   task automatic pick();
      rnd();
      x = seed[3:0];
      m = seed[13:4];
      lat <= seed[15:14];
      a = {5'h0, m} + (x == 4'h0 ? 15'h0 : IDX_REGS_I[15*x-1 -: 15]);
   endtask
   task automatic run(input logic [25:1] w);
      INSTR_I <= w;
      INSTR_VALID_I <= 1'h1;
      do @(posedge CLK_SYS_I); while (INSTR_READY_O !== 1'h1);
      INSTR_VALID_I <= 1'h0;
      do @(posedge CLK_SYS_I); while (INSTR_READY_O !== 1'h1 && HALTED_O !== 1'h1);
   endtask
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
      @(posedge CLK_SYS_I);
      q_axi.push_back({30'h0, r, 32'h0});
      AWADDR_I <= ad;
      WDATA_I <= d;
      AWVALID_I <= 1'h1;
      WVALID_I <= 1'h1;
      BREADY_I <= 1'h1;
      do begin
         @(posedge CLK_SYS_I);
         if (AWREADY_O === 1'h1) AWVALID_I <= 1'h0;
         if (WREADY_O === 1'h1) WVALID_I <= 1'h0;
      end while (BVALID_O !== 1'h1);
      BREADY_I <= 1'h0;
   endtask
   task automatic axi_rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
      @(posedge CLK_SYS_I);
      q_axi.push_back({1'h1, 29'h0, r, d});
      ARADDR_I <= ad;
      ARVALID_I <= 1'h1;
      RREADY_I <= 1'h1;
      do begin
         @(posedge CLK_SYS_I);
         if (ARREADY_O === 1'h1) ARVALID_I <= 1'h0;
      end while (RVALID_O !== 1'h1);
      RREADY_I <= 1'h0;
   endtask

   // result watcher: each result takes the oldest note of its kind
   always @(posedge CLK_SYS_I) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         report_and_stop();
      end
      if (!RST_I) begin
         if (DONE_O === 1'h1) chk({32'h0, IP_LOAD_O, ACC_WE_O, IP_STEP_O, ACC_WE_O ?
            {ACC_NUM_O, ACC_DATA_O} : IP_LOAD_O ? {13'h0, IP_VALUE_O} : 28'h0},
            q_done.size() ? q_done.pop_front() : 64'hx);
         if (MEM_REQ_O === 1'h1 && MEM_ACK_I === 1'h1) chk({21'h0, MEM_WE_O, MEM_ADDR_O,
            MEM_WE_O ? MEM_WDATA_O : 27'h0}, q_mem.size() ? q_mem.pop_front() : 64'hx);
         // panel selector switch is taken as parked at position 0, so each strobe lights
         if (PANEL_STB_O === 1'h1) chk({37'h0, PANEL_DATA_O},
            q_pan.size() ? q_pan.pop_front() : 64'hx);
         if (BVALID_O === 1'h1 && BREADY_I) chk({30'h0, BRESP_O, 32'h0},
            q_axi.size() ? q_axi.pop_front() : 64'hx);
         if (RVALID_O === 1'h1 && RREADY_I) chk({1'h1, 29'h0, RRESP_O, RRESP_O == `RESP_DECERR ?
            32'h0 : RDATA_O}, q_axi.size() ? q_axi.pop_front() : 64'hx);
         n_ovf += (OVF_SET_O === 1'h1);
         n_ill += (ILLEGAL_O === 1'h1);
         n_int += (TAKE_INT_O === 1'h1);
      end
   end

   initial begin
      for (int i = 0; i < 8; i++) begin
         rnd();
         IDX_REGS_I = {IDX_REGS_I[192:0], seed};
         if (i < 3) TAPE_STATUS_I = {TAPE_STATUS_I[63:0], seed};
      end
      repeat (4) @(posedge CLK_SYS_I);
      RST_I <= 1'h0;
      repeat (2) @(posedge CLK_SYS_I);
      axi_rd(`REG_CTRL, 32'h1, `RESP_OKAY);
      axi_rd(8'h40, 32'h0, `RESP_DECERR);
      for (int k = 0; k < 4; k++) begin
         pick();
         if (k == 2) begin
            q_mem.push_back({22'h0, a, 27'h0});
            a = a ^ 15'h0123;
         end
         q_mem.push_back({21'h0, 1'h1, a, 3'h0, TAPE_STATUS_I[24*k +: 24]});
         q_done.push_back(dn(1'h0, 1'h0, `STEP_ONE, 28'h0));
         run(ins(k == 2, x, `OP_STORE_TAPE, 4'h1 << k, m));
      end
      pick();
      q_done.push_back(dn(1'h0, 1'h0, `STEP_ONE, 28'h0));
      run(ins(1'h0, x, `OP_STORE_TAPE, 4'h3, m));
      pick();
      q_mem.push_back({22'h0, a, 27'h0});
      q_mem.push_back({22'h0, a ^ 15'h0123, 27'h0});
      q_pan.push_back({37'h0, a[11:0] ^ 12'h123, a});
      q_done.push_back(dn(1'h0, 1'h0, `STEP_ONE, 28'h0));
      run(ins(1'h1, x, `OP_SHOW, `SEL_NONE, m));
      q_done.push_back(dn(1'h0, 1'h0, `STEP_ONE, 28'h0));
      run(ins(1'h0, x, `OP_SHOW, 4'h2, m));
      // code outside the group: illegal pulse only, no done
      run(ins(1'h0, 4'h0, 6'h3d, 4'h0, 10'h0));
      for (int k = 0; k < 7; k++) begin
         rnd();
         h = seed[7:0] % 24;
         tm = {4'(h / 10), 4'(h % 10), 4'(seed[15:8] % 60 / 10), 4'(seed[15:8] % 60 % 10),
            4'(seed[19:16] % 10)};
         CLK_UPDATING_I <= (k == 1);
         CLK_TIME_I <= tm;
         CLK_POWER_LOST_I <= (k == 4 || k == 5);
         repeat (3) @(posedge CLK_SYS_I);
         q_done.push_back(dn(1'h0, 1'h1, k == 1 ? `STEP_ONE : `STEP_TWO,
            {nums[k % 4], 5'h0, tm}));
         run(ins(1'h0, 4'h0, `OP_CLOCK, sels[k % 4], k == 2 ? 10'h1 : 10'h0));
      end
      axi_wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      q_done.push_back(dn(1'h0, 1'h1, `STEP_ONE, {3'h2, 25'h0}));
      run(ins(1'h0, 4'h0, `OP_CLOCK, 4'h3, 10'h0));
      axi_rd(`REG_TIME, 32'h0, `RESP_OKAY);
      axi_wr(`REG_CTRL, 32'h1, `RESP_OKAY);
      pick();
      q_done.push_back(dn(1'h1, 1'h0, `STEP_LOAD, {13'h0, a}));
      run(ins(1'h0, x, `OP_WAIT, 4'h0, m));
      INT_PENDING_I <= 1'h1;
      repeat (4) @(posedge CLK_SYS_I);
      chk({62'h0, HALTED_O, INSTR_READY_O}, 64'h2);
      axi_rd(`REG_STATUS, 32'h5, `RESP_OKAY);
      axi_wr(`REG_STATUS, 32'h4, `RESP_OKAY);
      axi_rd(`REG_STATUS, 32'h1, `RESP_OKAY);
      PROGRAM_RUN_I <= 1'h1;
      repeat (4) @(posedge CLK_SYS_I);
      PROGRAM_RUN_I <= 1'h0;
      INT_PENDING_I <= 1'h0;
      repeat (4) @(posedge CLK_SYS_I);
      chk({62'h0, HALTED_O, INSTR_READY_O}, 64'h1);
      chk({32'h0, 8'(n_ill), 8'(n_ovf), 8'(n_int), 8'(q_done.size() + q_mem.size())},
         {32'h0, 8'h4, 8'h2, 8'h1, 8'h0});
      report_and_stop();
   end
endmodule
`default_nettype wire
